// [bench/tmra_asserts.sv]
// Port-level checks for the timer channel
`timescale 1ns/1ps
`default_nettype none
module tmra_asserts
#(
  parameter int CHANNEL = 0
)
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        clk_en,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        timer_output_pin,
  input wire logic        timer_output_pin_oe,
  input wire logic        irq
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_take;
    psel && penable && !pready && clk_en;
  endsequence
  property p_ack; s_take |=> pready; endproperty
  property p_idle; !(psel && penable) |=> !pready; endproperty
  property p_pulse; pready |=> !pready; endproperty
  property p_err; pslverr |-> pready; endproperty
  property p_err_rd; pready && pslverr && !pwrite |-> prdata == 32'h0;
  endproperty
  property p_frz_pin; !clk_en |=> $stable(timer_output_pin); endproperty
  property p_frz_irq; !clk_en ##1 !clk_en |-> $stable(irq); endproperty
  property p_nopin; (CHANNEL == 1 || CHANNEL == 2) |-> !timer_output_pin_oe;
  endproperty
  a_ack: assert property (p_ack)
    else $error("no ready after access");
  a_idle: assert property (p_idle)
    else $error("ready without access");
  a_pulse: assert property (p_pulse)
    else $error("ready longer than one cycle");
  a_err: assert property (p_err)
    else $error("error without ready");
  a_err_rd: assert property (p_err_rd)
    else $error("unmapped read not zero");
  a_frz_pin: assert property (p_frz_pin)
    else $error("pulse output moved while frozen");
  a_frz_irq: assert property (p_frz_irq)
    else $error("irq moved while frozen");
  a_nopin: assert property (p_nopin)
    else $error("pinless channel drives output");
endmodule
bind tmra_channel tmra_asserts #(.CHANNEL(CHANNEL)) tmra_asserts_inst (
  .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
  .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .timer_output_pin(timer_output_pin),
  .timer_output_pin_oe(timer_output_pin_oe), .irq(irq));
`default_nettype wire

// [bench/tmra_channel_tb.sv]
// Register-level test of the timer channel
`timescale 1ns/1ps
`default_nettype none
module tmra_channel_tb;
  import tmra_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        clk_en = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [4:0]  paddr = 5'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        pin_lvl;
  logic        dir_lvl;
  logic        dir_wire;
  logic        out_pin;
  logic        out_oe;
  logic        irq;
  logic [31:0] rd;
  logic        err;
  logic [15:0] v;
  int          i;
  int          error_cnt = 0;
  int          n_tests = 0;
  logic [31:0] md[3] = '{32'h0c05, 32'h0405, 32'h0105};
  logic [31:0] ld[3] = '{32'hfffd, 32'hfffe, 32'h0002};
  logic [31:0] ex[3] = '{32'h0002, 32'hffff, 32'h0001};
  int          np[3] = '{5, 3, 4};
  always #4 pclk = ~pclk;
  assign dir_wire = out_oe ? out_pin : dir_lvl;
  tmra_channel #(.CHANNEL(0)) tmra_channel_inst (.pclk(pclk),
    .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .subclock_tick(1'b0),
    .b_group_timer_two(1'b0), .other_a_group_timer(1'b0),
    .timer_input_pin(pin_lvl), .timer_output_pin_in(dir_wire),
    .timer_output_pin(out_pin), .timer_output_pin_oe(out_oe), .irq(irq));
  tmra_pins tmra_pins_inst (.pclk(pclk), .pin_lvl(pin_lvl),
    .dir_lvl(dir_lvl));
  task automatic results();
    $display("mismatches %0d of %0d checks", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, logic [4:0] a, logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1)
    begin
      error_cnt++;
      results();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    bus(0, TMRA_OFF_TIMER, 0);
    chk("timer reset", {16'h0, CNT_RESET}, rd);
    bus(0, TMRA_OFF_MODE, 0);
    chk("mode reset", 0, rd);
    bus(0, 5'h14, 0);
    chk("unmapped data", 0, rd);
    chk("unmapped err", 1, {31'h0, err});
    $display("reset test done");
    bus(1, TMRA_OFF_TIMER, 32'h40);
    bus(0, TMRA_OFF_TIMER, 0);
    chk("halted load", 32'h40, rd);
    bus(1, TMRA_OFF_MASK, 1);
    bus(1, TMRA_OFF_MODE, 32'h4);
    bus(1, TMRA_OFF_START, 1);
    bus(1, TMRA_OFF_TIMER, 32'h10);
    bus(0, TMRA_OFF_TIMER, 0);
    chk("running load", 1, {31'h0, rd > 32'h10 && rd < 32'h40});
    rd = 0;
    for (i = 0; i < 40 && rd[0] !== 1'b1; i++)
      bus(0, TMRA_OFF_STAT, 0);
    chk("underflow", 1, rd);
    bus(1, TMRA_OFF_START, 0);
    bus(0, TMRA_OFF_TIMER, 0);
    v = rd[15:0];
    bus(0, TMRA_OFF_TIMER, 0);
    chk("halted hold", {16'h0, v}, rd);
    chk("reload", 1, {31'h0, v <= 16'h10});
    chk("pulse", 1, {31'h0, out_pin});
    chk("irq set", 1, {31'h0, irq});
    bus(1, TMRA_OFF_MASK, 0);
    @(negedge pclk);
    chk("irq masked", 0, {31'h0, irq});
    bus(1, TMRA_OFF_MASK, 1);
    bus(1, TMRA_OFF_STAT, 1);
    @(negedge pclk);
    chk("irq cleared", 0, {31'h0, irq});
    @(posedge pclk);
    clk_en <= 1'b0;
    repeat (3) @(posedge pclk);
    clk_en <= 1'b1;
    bus(1, TMRA_OFF_MODE, 32'h18);
    bus(1, TMRA_OFF_TIMER, 32'h20);
    bus(1, TMRA_OFF_START, 1);
    repeat (10) @(posedge pclk);
    bus(0, TMRA_OFF_TIMER, 0);
    chk("gate closed", 32'h20, rd);
    bus(1, TMRA_OFF_START, 0);
    $display("timer test done");
    for (int k = 0; k < 3; k++)
    begin
      bus(1, TMRA_OFF_MODE, md[k]);
      bus(1, TMRA_OFF_TIMER, ld[k]);
      bus(1, TMRA_OFF_STAT, 1);
      bus(1, TMRA_OFF_START, 1);
      tmra_pins_inst.send(np[k]);
      repeat (4) @(posedge pclk);
      bus(1, TMRA_OFF_START, 0);
      bus(0, TMRA_OFF_TIMER, 0);
      chk("event count", ex[k], rd);
      bus(0, TMRA_OFF_STAT, 0);
      chk("event wrap", 1, rd);
      chk("event pulse", 32'(k % 2), {31'h0, out_pin});
      chk("pulse enable", 1, {31'h0, out_oe});
    end
    $display("event test done");
    results();
  end
endmodule
`default_nettype wire

// [bench/tmra_pins.sv]
// Far-side pin model: count pulses and direction level
`timescale 1ns/1ps
`default_nettype none
module tmra_pins
(
  input  wire logic pclk,
  output logic      pin_lvl,
  output logic      dir_lvl
);
  initial pin_lvl = 1'b0;
  initial dir_lvl = 1'b1;
  // Wide pulses so a synchroniser sees every edge
  task automatic send(input int n);
    repeat (n)
    begin
      repeat (3) @(posedge pclk);
      pin_lvl <= 1'b1;
      repeat (3) @(posedge pclk);
      pin_lvl <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// [pkg/tmra_pkg.sv]
// Constants, register map and mode encodings for the timer channel
// How it works
// - Timer mode counts selected internal prescaled source
// - Timer mode counts down, reloads on underflow
// - Start flag set runs, cleared halts counting
// - Timer mode underflow raises interrupt request
// - Timer register read returns current count
// - Write while halted loads reload and counter
// - Write while running loads only reload
// - Timer mode gate input level starts and stops counting
// - Timer mode pulse output toggles on underflow
// - Channels one and two have no pins
// - Event mode counts pin edges or overflows
// - No channel counts two-phase; HAS_2PH only marks channels two and up
// - Direction from software or output pin level
// - Event mode reloads on over/underflow unless free-run
// - Event mode interrupt on overflow and underflow
// - Event mode free-run wraps without reloading
// - Event mode pulse output toggles on wrap
// - Mode register low two bits pick mode
package tmra_pkg;
  localparam int          TMRA_AW        = 5;
  localparam logic [4:0]  TMRA_OFF_START = 5'h00;
  localparam logic [4:0]  TMRA_OFF_MODE  = 5'h04;
  localparam logic [4:0]  TMRA_OFF_TIMER = 5'h08;
  localparam logic [4:0]  TMRA_OFF_STAT  = 5'h0c;
  localparam logic [4:0]  TMRA_OFF_MASK  = 5'h10;
  // Mode register fields
  localparam int MD_MODE_LO  = 0;
  localparam int MD_PULSE    = 2;
  localparam int MD_GATE_EN  = 3;
  localparam int MD_GATE_POL = 4;
  localparam int MD_SRC_LO   = 6;
  localparam int MD_EDGE     = 8;
  localparam int MD_DIR_EXT  = 9;
  localparam int MD_DIR_UP   = 10;
  localparam int MD_FREE     = 11;
  localparam int MD_EVSRC_LO = 12;
  localparam int MD_WIDTH    = 14;
  localparam logic [13:0] MD_RESET = 14'h0000;
  localparam logic [15:0] CNT_MAX  = 16'hffff;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_RESET = 16'hffff;
  localparam logic [4:0]  PRE_DIV8  = 5'h07;
  localparam logic [4:0]  PRE_DIV32 = 5'h1f;
  typedef enum logic [1:0] {
    TMRA_TIMER = 2'h0, TMRA_EVENT = 2'h1,
    TMRA_ONESHOT = 2'h2, TMRA_PWM = 2'h3
  } tmra_mode_t;
  typedef enum logic [1:0] {
    TMRA_SRC_DIV1 = 2'h0, TMRA_SRC_DIV8 = 2'h1,
    TMRA_SRC_DIV32 = 2'h2, TMRA_SRC_SUB32 = 2'h3
  } tmra_src_t;
  typedef enum logic [1:0] {
    TMRA_EV_PIN = 2'h0, TMRA_EV_BGRP = 2'h1,
    TMRA_EV_OTHER = 2'h2, TMRA_EV_RSV = 2'h3
  } tmra_evsrc_t;
endpackage

// [src/tmra_channel.sv]
// One timer A channel: timer and single-phase event counter modes
`timescale 1ns/1ps
`default_nettype none
module tmra_channel
#(
  parameter int CHANNEL = 0
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [tmra_pkg::TMRA_AW-1:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        subclock_tick,
  input  wire logic        b_group_timer_two,
  input  wire logic        other_a_group_timer,
  input  wire logic        timer_input_pin,
  input  wire logic        timer_output_pin_in,
  output logic             timer_output_pin,
  output logic             timer_output_pin_oe,
  output logic             irq
);
  import tmra_pkg::*;

  // Channels without pins
  localparam bit HAS_PINS = (CHANNEL != 1) && (CHANNEL != 2);
  localparam bit HAS_2PH  = (CHANNEL >= 2);

  logic        start_q;
  logic [13:0] mode_q;
  logic [15:0] cnt_q, cnt_d;
  logic [15:0] reload_q;
  logic        pout_q;
  logic [1:0]  stat_q, mask_q;
  logic [4:0]  pre_q;
  logic [4:0]  subdiv_q;
  logic        pin_q, ev_src_q;
  logic [31:0] prdata_q;
  logic        pready_q, pslverr_q, irq_q;

  wire access  = psel & penable & ~pready_q;
  wire wr      = access & pwrite;
  wire rd      = access & ~pwrite;
  wire hit_start = paddr == TMRA_OFF_START;
  wire hit_mode  = paddr == TMRA_OFF_MODE;
  wire hit_timer = paddr == TMRA_OFF_TIMER;
  wire hit_stat  = paddr == TMRA_OFF_STAT;
  wire hit_mask  = paddr == TMRA_OFF_MASK;
  wire mapped = hit_start | hit_mode | hit_timer | hit_stat | hit_mask;

  // Mode field decode
  wire [1:0] mode_sel = mode_q[MD_MODE_LO+1:MD_MODE_LO];
  wire is_timer = mode_sel == TMRA_TIMER;
  wire is_event = mode_sel == TMRA_EVENT;
  wire [1:0] src_sel = mode_q[MD_SRC_LO+1:MD_SRC_LO];
  wire [1:0] ev_sel  = mode_q[MD_EVSRC_LO+1:MD_EVSRC_LO];
  wire pulse_en = mode_q[MD_PULSE] & HAS_PINS;
  wire gate_en  = mode_q[MD_GATE_EN] & HAS_PINS;
  wire free_run = mode_q[MD_FREE];

  // Internal prescaler: the subclock arrives as a tick already synced
  wire pre8  = (pre_q[2:0] == PRE_DIV8[2:0]);
  wire pre32 = (pre_q == PRE_DIV32);
  wire sub32 = subclock_tick & (subdiv_q == PRE_DIV32);
  logic src_tick;
  always_comb
  begin
    case (src_sel)
      TMRA_SRC_DIV1:  src_tick = 1'b1;
      TMRA_SRC_DIV8:  src_tick = pre8;
      TMRA_SRC_DIV32: src_tick = pre32;
      default:      src_tick = sub32;
    endcase
  end

  // Gate level: active level picked by polarity bit
  wire gate_ok = ~gate_en
    | (timer_input_pin == mode_q[MD_GATE_POL]);

  // Event sources, edge detected on the channel clock
  wire pin_rise = timer_input_pin & ~pin_q;
  wire pin_fall = ~timer_input_pin & pin_q;
  wire pin_edge = HAS_PINS
    & (mode_q[MD_EDGE] ? pin_fall : pin_rise);
  logic ev_raw;
  always_comb
  begin
    case (ev_sel)
      TMRA_EV_PIN:   ev_raw = pin_edge;
      TMRA_EV_BGRP:  ev_raw = b_group_timer_two & ~ev_src_q;
      TMRA_EV_OTHER: ev_raw = other_a_group_timer & ~ev_src_q;
      default:       ev_raw = 1'b0;
    endcase
  end
  wire ev_level = (ev_sel == TMRA_EV_BGRP) ? b_group_timer_two
                                          : other_a_group_timer;

  // Direction: external pin level overrides software when selected
  wire ext_dir = mode_q[MD_DIR_EXT] & HAS_PINS;
  wire count_up = ext_dir ? timer_output_pin_in
                          : mode_q[MD_DIR_UP];

  wire run = start_q;
  wire tick_t = is_timer & run & src_tick & gate_ok;
  wire tick_e = is_event & run & ev_raw;
  wire up_now = is_event & count_up;
  wire under = (tick_t | (tick_e & ~count_up)) & (cnt_q == CNT_ZERO);
  wire over  = tick_e & count_up & (cnt_q == CNT_MAX);
  wire wrap  = under | over;
  wire tmr_wr = wr & hit_timer;

  always_comb
  begin
    cnt_d = cnt_q;
    if (tmr_wr && !run)
      cnt_d = pwdata[15:0];
    else if (wrap && !(is_event && free_run))
      cnt_d = reload_q;
    else if (tick_t || tick_e)
      cnt_d = up_now ? cnt_q + 16'h0001
                     : cnt_q - 16'h0001;
  end

  wire [31:0] rd_mux =
      hit_start ? {31'h0, start_q}
    : hit_mode  ? {18'h0, mode_q}
    : hit_timer ? {16'h0, cnt_q}
    : hit_stat  ? {30'h0, stat_q}
    : hit_mask  ? {30'h0, mask_q}
    : 32'h0;

  // Status: bit0 wrap event, bit1 spare; set wins over write-one clear
  wire [1:0] stat_set = {1'b0, wrap};
  wire [1:0] stat_clr = (wr & hit_stat) ? pwdata[1:0] : 2'h0;
  wire [1:0] stat_d = stat_set | (stat_q & ~stat_clr);
  // Two-phase counting is not built; keep unused capability visible
  wire unused_ok = HAS_2PH;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      start_q  <= 1'b0;
      mode_q   <= MD_RESET;
      cnt_q    <= CNT_RESET;
      reload_q <= CNT_RESET;
      pout_q   <= 1'b0;
      stat_q   <= 2'h0;
      mask_q   <= 2'h0;
      pre_q    <= 5'h00;
      subdiv_q <= 5'h00;
      pin_q    <= 1'b0;
      ev_src_q <= 1'b0;
      prdata_q <= 32'h0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      irq_q    <= 1'b0;
    end
    else if (clk_en)
    begin
      pre_q    <= pre_q + 5'h01;
      if (subclock_tick)
        subdiv_q <= subdiv_q + 5'h01;
      pin_q    <= timer_input_pin;
      ev_src_q <= ev_level;
      cnt_q    <= cnt_d;
      stat_q   <= stat_d;
      irq_q    <= (|(stat_d & mask_q)) | (unused_ok & 1'b0);
      if (wrap && pulse_en && (is_timer || is_event))
        pout_q <= ~pout_q;
      if (wr && hit_start)
        start_q <= pwdata[0];
      if (wr && hit_mode)
        mode_q <= pwdata[MD_WIDTH-1:0];
      if (tmr_wr)
        reload_q <= pwdata[15:0];
      if (wr && hit_mask)
        mask_q <= pwdata[1:0];
      pready_q  <= access;
      pslverr_q <= access & ~mapped;
      if (rd)
        prdata_q <= rd_mux;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign irq     = irq_q;
  assign timer_output_pin    = pout_q;
  // Pin driven only in pulse output mode and never as direction input
  logic oe_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      oe_q <= 1'b0;
    else if (clk_en)
      oe_q <= pulse_en & ~ext_dir;
  end
  assign timer_output_pin_oe = oe_q;
endmodule
`default_nettype wire
